//--- rtl/adc_seq_pkg.sv
`default_nettype none
package adc_seq_pkg;
  localparam int          RESULT_W       = 12;
  localparam int          PIN_N          = 3;
  localparam int          CONV_CLOCKS    = 16;
  localparam logic [4:0]  CONV_CLOCKS_M1 = 5'h0F;
  localparam logic [2:0]  DIV_RESET      = 3'h0;
  localparam logic [11:0] FULL_SCALE     = 12'hFFF;
  localparam real         CLK_PERIOD_NS  = 40.0;
  localparam real         MIN_CONV_CLK_NS = 500.0;
  localparam int          MIN_CONV_CLK_CYC = int'((MIN_CONV_CLK_NS + CLK_PERIOD_NS - 1.0)
                                                  / CLK_PERIOD_NS);

  typedef struct packed {
    logic [2:0] divSel;
    logic       powerOff;
    logic [2:0] analogPinSelect;
    logic [1:0] channel;
  } conv_cfg_s;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_ARMED = 3'b010,
    ST_CONV  = 3'b100
  } conv_state_e;

  // Divide ratio minus one; 011 and 111 fall back to the largest ratio
  function automatic logic [4:0] div_limit(input logic [2:0] sel);
    unique case (sel)
      3'h0:    div_limit = 5'h01;
      3'h1:    div_limit = 5'h07;
      3'h2:    div_limit = 5'h1F;
      3'h4:    div_limit = 5'h00;
      3'h5:    div_limit = 5'h03;
      3'h6:    div_limit = 5'h0F;
      default: div_limit = 5'h1F;
    endcase
  endfunction
endpackage
`default_nettype wire

//--- rtl/adc_sequence_control.sv
`default_nettype none
module adc_sequence_control
(
  // Clock and reset
  input  wire logic                     sys_clk,
  input  wire logic                     rst_b,
  // Configuration from software
  input  wire adc_seq_pkg::conv_cfg_s   cfg,
  input  wire logic                     startBit,
  input  wire logic                     global_interrupt_enable,
  input  wire logic                     conv_interrupt_enable,
  input  wire logic                     stackFull,
  input  wire logic                     requestClear,
  // Port pin control
  input  wire logic [2:0]               port_a_direction_register,
  input  wire logic [2:0]               pullUpEnable,
  output logic      [2:0]               pinOutEnableMask,
  output logic      [2:0]               pullUpActive,
  output logic      [2:0]               analogConnect,
  // Converter core
  input  wire logic [11:0]              coreData,
  output logic      [1:0]               channelSelect,
  output logic                          convPowerOn,
  output logic                          convClkEn,
  output logic                          coreReset,
  // Status and result
  output logic                          conversion_pending_flag,
  output logic                          requestFlag,
  output logic                          interruptReq,
  output logic      [11:0]              result
);
  adc_seq_pkg::conv_state_e state;
  adc_seq_pkg::conv_state_e next_state;
  logic [4:0]  divCnt;
  logic [4:0]  next_divCnt;
  logic [4:0]  convCnt;
  logic [4:0]  next_convCnt;
  logic        startPrev;
  logic        pending;
  logic        next_pending;
  logic        req;
  logic        next_req;
  logic [11:0] next_result;
  logic        tick;
  logic        powerOn;
  logic        done;
  logic        startRise;
  logic [2:0]  next_pinOutEnableMask;
  logic [2:0]  next_pullUpActive;
  logic [2:0]  next_analogConnect;
  logic [1:0]  next_channelSelect;
  logic        next_convPowerOn;
  logic        next_convClkEn;
  logic        next_coreReset;
  logic        next_interruptReq;
  logic [4:0]  tickTally;
  logic [4:0]  next_tickTally;

  // Power depends only on pin select and power-off bit, never halt
  assign powerOn = (cfg.analogPinSelect != 3'h0) && !cfg.powerOff;
  // At or past the limit, so a lowered ratio never wraps through 31
  assign tick    = powerOn && (divCnt >= adc_seq_pkg::div_limit(cfg.divSel));
  assign startRise = startBit && !startPrev;
  // A restart on the last tick wins over completion
  assign done    = (state == adc_seq_pkg::ST_CONV) && tick && !startRise
                   && (convCnt == adc_seq_pkg::CONV_CLOCKS_M1);

  always_comb
  begin
    next_state   = state;
    next_convCnt = convCnt;
    next_pending = pending;
    next_result  = result;
    next_req     = req;
    next_divCnt  = tick || !powerOn ? 5'h00 : divCnt + 5'h01;
    if (requestClear)
    begin
      next_req = 1'b0;
    end
    unique case (state)
      adc_seq_pkg::ST_IDLE:
      begin
        if (startBit && !startPrev)
        begin
          next_state   = adc_seq_pkg::ST_ARMED;
          next_pending = 1'b1;
        end
      end
      adc_seq_pkg::ST_ARMED:
      begin
        // Held high keeps the core in reset; the falling edge launches
        if (!startBit)
        begin
          next_state   = adc_seq_pkg::ST_CONV;
          next_convCnt = 5'h00;
        end
      end
      adc_seq_pkg::ST_CONV:
      begin
        if (startBit && !startPrev)
        begin
          next_state = adc_seq_pkg::ST_ARMED;
        end
        else if (done)
        begin
          next_state   = adc_seq_pkg::ST_IDLE;
          next_pending = 1'b0;
          next_result  = coreData;
          next_req     = 1'b1;
        end
        else if (tick)
        begin
          next_convCnt = convCnt + 5'h01;
        end
      end
    endcase
  end

  // Pin and core controls follow their settings one cycle later
  always_comb
  begin
    next_pinOutEnableMask = ~port_a_direction_register & ~cfg.analogPinSelect;
    next_pullUpActive     = pullUpEnable & ~cfg.analogPinSelect;
    next_analogConnect    = cfg.analogPinSelect;
    next_channelSelect    = cfg.channel;
    next_convPowerOn      = powerOn;
    next_convClkEn        = tick && (state == adc_seq_pkg::ST_CONV);
    next_coreReset        = (next_state == adc_seq_pkg::ST_ARMED);
    // Request stays sticky so a blocked interrupt can be polled later
    next_interruptReq     = next_req && global_interrupt_enable
                            && conv_interrupt_enable && !stackFull;
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state                   <= adc_seq_pkg::ST_IDLE;
      divCnt                  <= 5'h00;
      convCnt                 <= 5'h00;
      startPrev               <= 1'b0;
      pending                 <= 1'b0;
      req                     <= 1'b0;
      result                  <= 12'h000;
      pinOutEnableMask        <= 3'h0;
      pullUpActive            <= 3'h0;
      analogConnect           <= 3'h0;
      channelSelect           <= 2'h0;
      convPowerOn             <= 1'b0;
      convClkEn               <= 1'b0;
      coreReset               <= 1'b1;
      conversion_pending_flag <= 1'b0;
      requestFlag             <= 1'b0;
      interruptReq            <= 1'b0;
    end
    else
    begin
      state                   <= next_state;
      divCnt                  <= next_divCnt;
      convCnt                 <= next_convCnt;
      startPrev               <= startBit;
      pending                 <= next_pending;
      req                     <= next_req;
      result                  <= next_result;
      pinOutEnableMask        <= next_pinOutEnableMask;
      pullUpActive            <= next_pullUpActive;
      analogConnect           <= next_analogConnect;
      channelSelect           <= next_channelSelect;
      convPowerOn             <= next_convPowerOn;
      convClkEn               <= next_convClkEn;
      coreReset               <= next_coreReset;
      conversion_pending_flag <= next_pending;
      requestFlag             <= next_req;
      interruptReq            <= next_interruptReq;
    end
  end

  // Converter clock pulses since the core left reset, for the length check
  always_comb
  begin
    next_tickTally = coreReset ? 5'h00 : tickTally + {4'h0, convClkEn};
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      tickTally <= 5'h00;
    end
    else
    begin
      tickTally <= next_tickTally;
    end
  end

  sequence s_start_rise;
    startBit && !startPrev;
  endsequence

  sequence s_launch;
    (state == adc_seq_pkg::ST_ARMED) && !startBit;
  endsequence

  a_pend_clear: assert property (@(posedge sys_clk) disable iff (!rst_b)
    done |=> !conversion_pending_flag && result == $past(coreData))
    else $error("pending not cleared or result not loaded at end");
  a_req_set: assert property (@(posedge sys_clk) disable iff (!rst_b)
    done |=> requestFlag) else $error("request flag not set at end");
  a_irq_gate: assert property (@(posedge sys_clk) disable iff (!rst_b)
    interruptReq == (requestFlag && $past(global_interrupt_enable && conv_interrupt_enable
                     && !stackFull))) else $error("interrupt not gated");
  a_hold_start: assert property (@(posedge sys_clk) disable iff (!rst_b)
    s_start_rise |=> conversion_pending_flag && coreReset)
    else $error("start rise did not set pending");
  a_launch: assert property (@(posedge sys_clk) disable iff (!rst_b)
    s_launch |=> !coreReset && conversion_pending_flag)
    else $error("falling start did not launch");
  a_power_gate: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (cfg.analogPinSelect == 3'h0) |=> !convPowerOn) else $error("converter powered with no pins");
  a_pullup_off: assert property (@(posedge sys_clk) disable iff (!rst_b)
    ##1 (pullUpActive & $past(cfg.analogPinSelect)) == 3'h0) else $error("pull-up on analog pin");
  a_div_two: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (tick && cfg.divSel == 3'h0 && powerOn) ##1 (cfg.divSel == 3'h0 && powerOn) |-> !tick)
    else $error("divide by two ticked twice in a row");
  a_hold_result: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !done |=> $stable(result)) else $error("result changed without completion");
  a_conv_len: assert property (@(posedge sys_clk) disable iff (!rst_b)
    $fell(conversion_pending_flag) |-> convClkEn && tickTally == 5'h0F)
    else $error("conversion length wrong");
  a_power_on: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (cfg.analogPinSelect != 3'h0 && !cfg.powerOff) |=> convPowerOn)
    else $error("converter not powered");
  a_power_off: assert property (@(posedge sys_clk) disable iff (!rst_b)
    cfg.powerOff |=> !convPowerOn) else $error("converter powered while off");
  a_dir_ignore: assert property (@(posedge sys_clk) disable iff (!rst_b)
    ##1 (pinOutEnableMask & $past(cfg.analogPinSelect)) == 3'h0)
    else $error("analog pin driven as output");
  a_route_pin: assert property (@(posedge sys_clk) disable iff (!rst_b)
    ##1 analogConnect == $past(cfg.analogPinSelect)) else $error("analog routing wrong");
  a_chan_sel: assert property (@(posedge sys_clk) disable iff (!rst_b)
    ##1 channelSelect == $past(cfg.channel)) else $error("channel select wrong");
endmodule
`default_nettype wire

//--- verif/adc_sequence_control_tb.sv
`default_nettype none
module adc_sequence_control_tb;
  timeunit 1ns;
  timeprecision 1ns;
  adc_seq_pkg::conv_cfg_s cfg = '0;
  logic sys_clk = 1'b0, rst_b = 1'b0, startBit = 1'b0, gIe = 1'b0, cIe = 1'b0;
  logic stackFull = 1'b0, reqClr = 1'b0, pwrOn, clkEn, coreRst, pending, reqFlag, irq;
  logic [2:0] dir = '0, pullEn = '0, oeMask, pullAct, anaConn;
  logic [1:0] chSel;
  logic [11:0] coreData, result;
  logic [3:0][11:0] levels = '0;
  logic [31:0] seed = 32'hF1BAF482;
  // Early fast codes fall below the minimum period; the ideal model stays exact
  logic [2:0] sels [8] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h5, 3'h6, 3'h6, 3'h2};
  int badCount = 0, compares = 0, cyc = 0;
  adc_sequence_control dut_u (.sys_clk(sys_clk), .rst_b(rst_b), .cfg(cfg), .startBit(startBit),
    .global_interrupt_enable(gIe), .conv_interrupt_enable(cIe), .stackFull(stackFull),
    .requestClear(reqClr), .port_a_direction_register(dir), .pullUpEnable(pullEn),
    .pinOutEnableMask(oeMask), .pullUpActive(pullAct), .analogConnect(anaConn),
    .coreData(coreData), .channelSelect(chSel), .convPowerOn(pwrOn), .convClkEn(clkEn),
    .coreReset(coreRst), .conversion_pending_flag(pending), .requestFlag(reqFlag),
    .interruptReq(irq), .result(result));
  conv_core_model model_u (.sys_clk(sys_clk), .channelSelect(chSel), .convPowerOn(pwrOn),
    .levels(levels), .coreData(coreData));
  always #20 sys_clk = ~sys_clk;
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic int ratio(input logic [2:0] sel);
    case (sel)
      3'h0: return 2;
      3'h1: return 8;
      3'h4: return 1;
      3'h5: return 4;
      3'h6: return 16;
      default: return 32;
    endcase
  endfunction
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      badCount++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic endSim();
    $display("compares %0d badCount %0d", compares, badCount);
    if (badCount == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic convert(input logic [2:0] sel, input int hold);
    int n;
    int pulses;
    logic [11:0] keep;
    n = 0;
    pulses = 0;
    @(posedge sys_clk);
    cfg.divSel <= sel;
    startBit <= 1'b1;
    repeat (hold) @(posedge sys_clk);
    #1;
    check("pending", pending, 1);
    check("coreReset", coreRst, 1);
    @(posedge sys_clk);
    startBit <= 1'b0;
    while (pending === 1'b1 && n < 2000)
    begin
      @(posedge sys_clk);
      #1;
      n++;
      pulses += (clkEn === 1'b1) ? 1 : 0;
    end
    check("convTime", n >= 15 * ratio(sel) && n <= 16 * ratio(sel) + 5, 1);
    check("clkTicks", pulses, adc_seq_pkg::CONV_CLOCKS);
    check("result", result, levels[cfg.channel]);
    check("request", reqFlag, 1);
    check("irq", irq, gIe & cIe & ~stackFull);
    keep = result;
    levels <= ~levels;
    repeat (3) @(posedge sys_clk);
    reqClr <= 1'b1;
    @(posedge sys_clk);
    reqClr <= 1'b0;
    repeat (2) @(posedge sys_clk);
    #1;
    check("held", result, keep);
    check("cleared", reqFlag, 0);
    check("irqCleared", irq, 0);
    $display("conversion with divider %0h done", sel);
  endtask
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      badCount++;
      endSim();
    end
  end
  initial
  begin
    logic [31:0] r;
    repeat (2) @(posedge sys_clk);
    rst_b <= 1'b1;
    for (int i = 0; i < 24; i++)
    begin
      @(posedge sys_clk);
      r = rnd();
      cfg <= adc_seq_pkg::conv_cfg_s'(r[8:0]);
      dir <= r[11:9];
      pullEn <= (i == 0) ? 3'h7 : r[14:12];
      repeat (2) @(posedge sys_clk);
      #1;
      check("oe", oeMask, 3'(~dir & ~cfg.analogPinSelect));
      check("pull", pullAct, pullEn & ~cfg.analogPinSelect);
      check("analog", anaConn, cfg.analogPinSelect);
      check("power", pwrOn, (|cfg.analogPinSelect) & ~cfg.powerOff);
      check("channel", chSel, cfg.channel);
    end
    $display("pin mapping done");
    for (int j = 0; j < 8; j++)
    begin
      @(posedge sys_clk);
      r = rnd();
      cfg.channel <= (r[1:0] == 2'h3) ? 2'h0 : r[1:0];
      cfg.analogPinSelect <= r[4:2] | 3'h1;
      cfg.powerOff <= 1'b0;
      gIe <= r[5];
      cIe <= r[6];
      stackFull <= r[7];
      levels <= (j == 5) ? {4{adc_seq_pkg::FULL_SCALE}} : {rnd(), r[31:16]};
      // Last two codes keep the converter clock above its minimum period
      if (j >= 6)
        check("minPeriod", ratio(sels[j]) >= adc_seq_pkg::MIN_CONV_CLK_CYC, 1);
      convert(sels[j], (j == 3) ? 6 : 2);
    end
    endSim();
  end
endmodule
`default_nettype wire

//--- verif/conv_core_model.sv
`default_nettype none
module conv_core_model
(
  // Clock
  input  wire logic             sys_clk,
  // Converter controls
  input  wire logic [1:0]       channelSelect,
  input  wire logic             convPowerOn,
  input  wire logic [3:0][11:0] levels,
  // Sampled code
  output logic      [11:0]      coreData
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [11:0] last = 12'h000;
  // Unpowered core drives nothing valid, so the code keeps changing
  always @(posedge sys_clk)
    last <= convPowerOn ? levels[channelSelect] : ~last;
  assign coreData = convPowerOn ? levels[channelSelect] : last;
endmodule
`default_nettype wire
